//--- esc_pkg.sv
package esc_pkg;
  // system clock 10 MHz
  localparam int unsigned CLK_KHZ          = 10000;
  localparam int unsigned CLK_NS           = 100;
  // timing figures in their own units
  localparam int unsigned BLANK_MIN_NS     = 4000;
  localparam int unsigned BLANK_MAX_NS     = 28000;
  localparam int unsigned OKF_FALL_US      = 120;
  localparam int unsigned SS_LIMIT_US      = 3500;
  localparam int unsigned SYNC_MIN_KHZ     = 200;
  localparam int unsigned SYNC_MAX_KHZ     = 2200;
  localparam int unsigned EDGE_MIN_NS      = 100;
  // derived cycle counts
  localparam int unsigned BLANK_CYC        = (BLANK_MAX_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned OKF_FALL_CYC     = OKF_FALL_US * 1000 / CLK_NS;
  localparam int unsigned SS_LIMIT_CYC     = SS_LIMIT_US * 1000 / CLK_NS;
  localparam int unsigned SYNC_PER_MAX_CYC = CLK_KHZ / SYNC_MIN_KHZ;
  localparam int unsigned SYNC_PER_MIN_CYC = (CLK_KHZ + SYNC_MAX_KHZ - 1) / SYNC_MAX_KHZ;
  localparam int unsigned EDGE_MIN_CYC     = (EDGE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned LOCK_CYCLES      = 2048;
  localparam int unsigned ALIGN_STEPS      = 32;
  // enable level decode
  typedef enum logic [1:0] {
    ESC_OFF     = 2'b00,
    ESC_STANDBY = 2'b01,
    ESC_RUN     = 2'b10
  } esc_mode_e;
  // clock lock sequence
  typedef enum logic [1:0] {
    ESC_FREE  = 2'b00,
    ESC_COUNT = 2'b01,
    ESC_ALIGN = 2'b10,
    ESC_LOCK  = 2'b11
  } esc_lock_e;
endpackage : esc_pkg

//--- esc_sync2.sv
`timescale 1ns/1ps
// two-flop synchroniser for a level
module esc_sync2 (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic d_i,
  output logic      q_o
);
  typedef struct packed {
    logic s1;
    logic s2;
  } esc_sy_s;
  esc_sy_s st_reg;
  esc_sy_s st_next;

  // first stage feeds only the second
  always_comb begin
    st_next.s1 = d_i;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.s2;
endmodule : esc_sync2

//--- esc_edge_det.sv
`timescale 1ns/1ps
// link-domain sync pulse detector: width check, toggle per valid rising edge
module esc_edge_det #(
  parameter int unsigned MIN_W = 1,
  parameter int unsigned MAX_W = 8
) (
  input  wire logic sync_clk_i,
  input  wire logic sync_rst_i,
  input  wire logic amp_ok_i,
  input  wire logic pin_i,
  output logic      tog_o,
  output logic      bad_tog_o
);
  // widths must fit the 8-bit pulse counter
  if (MIN_W < 1 || MAX_W <= MIN_W || MAX_W > 255) begin : g_bad_width
    $error("esc_edge_det bad widths");
  end
  typedef struct packed {
    logic       prev;
    logic [7:0] wid;
    logic       hi_ok;
    logic       tog;
    logic       bad;
  } esc_ed_s;
  esc_ed_s st_reg;
  esc_ed_s st_next;

  // pin and amplitude come in through link-domain synchronisers
  always_comb begin
    st_next      = st_reg;
    st_next.prev = pin_i;
    if (pin_i != st_reg.prev) begin
      st_next.wid = 8'h01;
      if (!pin_i) begin
        st_next.hi_ok = (st_reg.wid >= 8'(MIN_W)) && (st_reg.wid < 8'(MAX_W));
      end else if (amp_ok_i && st_reg.hi_ok &&
                   st_reg.wid >= 8'(MIN_W) && st_reg.wid < 8'(MAX_W)) begin
        st_next.tog = ~st_reg.tog;
      end else begin
        st_next.bad = ~st_reg.bad;
      end
    end else if (st_reg.wid != 8'hff) begin
      st_next.wid = st_reg.wid + 8'h01;
    end
  end

  always_ff @(posedge sync_clk_i) begin
    if (sync_rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tog_o     = st_reg.tog;
  assign bad_tog_o = st_reg.bad;
endmodule : esc_edge_det

//--- esc_ctrl.sv
`timescale 1ns/1ps
// Operation
// - low input below wake keeps shutdown
// - mid level: supply on, switch node idle
// - above enable and supply ok: switching
// - edge starts blanking; enable changes ignored
// - no blanking while in shutdown
// - sync accepted only within frequency range
// - valid edge: amplitude and pulse widths ok
// - after 2048 valid cycles adopt sync frequency
// - valid sync disables spread spectrum
// - changeover cycle has intermediate length; here only an internal changeover bit set for one clock
// - phase slides until edges coincide; here lock also comes after 32 nudges without coincidence
// - bad frequency resistor shuts device down
// - flag low when feedback outside window
// - short excursions do not drop flag
// - enable low forces flag low
// - fall filter lasts 120 us
// - flag low through soft start
module esc_ctrl
  import esc_pkg::*;
#(
  parameter int unsigned OKF_FALL_CYCLES = OKF_FALL_CYC,
  parameter int unsigned SS_CYCLES       = SS_LIMIT_CYC,
  parameter int unsigned LOCK_COUNT      = LOCK_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic sync_clk_i,
  input  wire logic sync_rst_i,
  input  wire logic en_wake_i,
  input  wire logic en_high_i,
  input  wire logic sync_amp_ok_i,
  input  wire logic vin_ok_i,
  input  wire logic vin_min_i,
  input  wire logic rt_ok_i,
  input  wire logic fb_in_window_i,
  input  wire logic ss_done_i,
  input  wire logic osc_tick_i,
  output logic      vcc_on_o,
  output logic      switch_node_en_o,
  output logic      spread_en_o,
  output logic      sync_locked_o,
  output logic      use_sync_clk_o,
  output logic      phase_adv_o,
  output logic      phase_ret_o,
  output logic      output_ok_flag_o,
  output logic      output_ok_flag_oe_o
);
  // counters are 16, 20 and 12 bits wide; the flag filter needs two steps
  if (OKF_FALL_CYCLES < 2 || OKF_FALL_CYCLES > 16'hffff || SS_CYCLES < 1 ||
      SS_CYCLES > 20'hfffff || LOCK_COUNT < 2 || LOCK_COUNT > 4095 ||
      BLANK_CYC > 16'hffff) begin : g_bad_param
    $error("esc_ctrl bad parameters");
  end

  // link-domain synchronisers: the pin and the amplitude detector are asynchronous
  logic pin_l;
  logic amp_l;
  esc_sync2 u_l0 (
    .clk_i     (sync_clk_i),
    .sys_rst_i (sync_rst_i),
    .d_i       (en_high_i),
    .q_o       (pin_l)
  );
  esc_sync2 u_l1 (
    .clk_i     (sync_clk_i),
    .sys_rst_i (sync_rst_i),
    .d_i       (sync_amp_ok_i),
    .q_o       (amp_l)
  );

  // link-side detector, counted in sync-clock cycles
  logic link_tog;
  logic link_bad;
  esc_edge_det #(
    .MIN_W (1),
    .MAX_W (BLANK_CYC / 3)
  ) u_det (
    .sync_clk_i (sync_clk_i),
    .sync_rst_i (sync_rst_i),
    .amp_ok_i   (amp_l),
    .pin_i      (pin_l),
    .tog_o      (link_tog),
    .bad_tog_o  (link_bad)
  );

  // crossings into the oscillator domain
  logic tog_s, bad_s, wake_s, high_s, vmin_s, vok_s, rt_s, fbw_s, ssd_s;
  esc_sync2 u_s0 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .d_i(link_tog),       .q_o(tog_s));
  esc_sync2 u_s1 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .d_i(link_bad),       .q_o(bad_s));
  esc_sync2 u_s2 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .d_i(en_wake_i),      .q_o(wake_s));
  esc_sync2 u_s3 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .d_i(en_high_i),      .q_o(high_s));
  esc_sync2 u_s4 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .d_i(vin_min_i),      .q_o(vmin_s));
  esc_sync2 u_s5 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .d_i(vin_ok_i),       .q_o(vok_s));
  esc_sync2 u_s6 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .d_i(rt_ok_i),        .q_o(rt_s));
  esc_sync2 u_s7 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .d_i(fb_in_window_i), .q_o(fbw_s));
  esc_sync2 u_s8 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .d_i(ss_done_i),      .q_o(ssd_s));

  typedef struct packed {
    esc_mode_e   mode;
    logic        en_lvl;
    logic [15:0] blank;
    logic        tog_d;
    logic        bad_d;
    esc_lock_e   lock;
    logic [11:0] vcnt;
    logic [15:0] per;
    logic [15:0] gap;
    logic [5:0]  align;
    logic        adv;
    logic        ret;
    logic        changeover;
    logic [19:0] ss;
    logic        ss_end;
    logic [15:0] okf;
    logic        flag;
  } esc_st_s;
  esc_st_s st_reg;
  esc_st_s st_next;

  logic edge_ev;
  logic bad_ev;
  logic per_ok;
  logic run_cond;
  assign edge_ev  = tog_s ^ st_reg.tog_d;
  assign bad_ev   = bad_s ^ st_reg.bad_d;
  // period between edges within 200 kHz .. 2.2 MHz
  assign per_ok   = (st_reg.gap >= 16'(SYNC_PER_MIN_CYC)) &&
                    (st_reg.gap <= 16'(SYNC_PER_MAX_CYC));
  assign run_cond = st_reg.en_lvl && vmin_s && vok_s && rt_s;

  // next-state logic
  always_comb begin
    st_next       = st_reg;
    st_next.tog_d = tog_s;
    st_next.bad_d = bad_s;
    st_next.adv   = 1'b0;
    st_next.ret   = 1'b0;
    st_next.changeover = 1'b0;

    // enable level with blanking after sync edges
    if (st_reg.blank != 16'h0000) begin
      st_next.blank = st_reg.blank - 16'h0001;
    end else begin
      st_next.en_lvl = high_s;
    end
    if (edge_ev && st_reg.mode != ESC_OFF) begin
      st_next.blank = 16'(BLANK_CYC);
    end

    // mode decode
    // a resistor out of range shuts down whatever the pin says
    if ((!wake_s && st_reg.blank == 16'h0000) || !rt_s) begin
      st_next.mode = ESC_OFF;
    end else if (run_cond) begin
      st_next.mode = ESC_RUN;
    end else begin
      st_next.mode = ESC_STANDBY;
    end

    // sync period measurement and lock sequence
    if (st_reg.gap != 16'hffff) begin
      st_next.gap = st_reg.gap + 16'h0001;
    end
    if (st_reg.mode != ESC_RUN || bad_ev ||
        st_reg.gap > 16'(SYNC_PER_MAX_CYC)) begin
      st_next.lock = ESC_FREE;
      st_next.vcnt = 12'h000;
      st_next.align = 6'h00;
    end
    if (edge_ev && st_reg.mode == ESC_RUN && !bad_ev) begin
      st_next.gap = 16'h0001;
      if (!per_ok) begin
        st_next.lock = ESC_FREE;
        st_next.vcnt = 12'h000;
      end else begin
        st_next.per = st_reg.gap;
        unique case (st_reg.lock)
          ESC_FREE: begin
            st_next.lock = ESC_COUNT;
            st_next.vcnt = 12'h001;
          end
          ESC_COUNT: begin
            if (st_reg.vcnt >= 12'(LOCK_COUNT - 1)) begin
              st_next.lock = ESC_ALIGN;
              st_next.changeover = 1'b1;
              st_next.align = 6'h00;
            end else begin
              st_next.vcnt = st_reg.vcnt + 12'h001;
            end
          end
          ESC_ALIGN: begin
            // step phase toward the edge, one nudge per cycle
            if (osc_tick_i) begin
              st_next.align = 6'(ALIGN_STEPS);
              st_next.lock  = ESC_LOCK;
            end else begin
              st_next.adv   = (st_reg.gap > (st_reg.per >> 1));
              st_next.ret   = ~st_next.adv;
              st_next.align = st_reg.align + 6'h01;
              if (st_reg.align == 6'(ALIGN_STEPS - 1)) begin
                st_next.lock = ESC_LOCK;
              end
            end
          end
          ESC_LOCK: begin
            st_next.lock = ESC_LOCK;
          end
        endcase
      end
    end

    // soft-start window
    if (st_reg.mode != ESC_RUN) begin
      st_next.ss     = 20'h00000;
      st_next.ss_end = 1'b0;
    end else if (ssd_s || st_reg.ss >= 20'(SS_CYCLES - 1)) begin
      st_next.ss_end = 1'b1;
    end else begin
      st_next.ss = st_reg.ss + 20'h00001;
    end

    // flag with falling filter
    if (st_reg.mode != ESC_RUN || !st_reg.ss_end) begin
      st_next.flag = 1'b0;
      st_next.okf  = 16'h0000;
    end else if (fbw_s) begin
      st_next.okf  = 16'h0000;
      st_next.flag = 1'b1;
    end else if (st_reg.okf >= 16'(OKF_FALL_CYCLES - 1)) begin
      st_next.flag = 1'b0;
    end else begin
      st_next.okf = st_reg.okf + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs
  assign vcc_on_o            = st_reg.mode != ESC_OFF;
  assign switch_node_en_o    = st_reg.mode == ESC_RUN;
  assign use_sync_clk_o      = st_reg.lock == ESC_ALIGN || st_reg.lock == ESC_LOCK;
  assign spread_en_o         = !use_sync_clk_o && st_reg.lock == ESC_FREE;
  assign sync_locked_o       = st_reg.lock == ESC_LOCK;
  assign phase_adv_o         = st_reg.adv;
  assign phase_ret_o         = st_reg.ret;
  assign output_ok_flag_o    = 1'b0;
  assign output_ok_flag_oe_o = !st_reg.flag;                             // open drain pulls low

  // assertions: enable decode and blanking
  a_off_no_switch: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_reg.mode == ESC_OFF |-> !switch_node_en_o && !vcc_on_o)
    else $error("switching while shut down");
  a_standby_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_reg.mode == ESC_STANDBY |-> vcc_on_o && !switch_node_en_o)
    else $error("standby drives switch node");
  a_run_needs_vin: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(switch_node_en_o) |-> $past(vmin_s) && $past(vok_s) && $past(rt_s))
    else $error("started without supply or resistor");
  a_blank_holds: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_reg.blank != 16'h0000 |=> st_reg.en_lvl == $past(st_reg.en_lvl))
    else $error("enable changed in blanking");
  a_blank_arm: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    edge_ev && st_reg.mode != ESC_OFF |=> st_reg.blank == 16'(BLANK_CYC))
    else $error("sync edge did not start blanking");
  a_no_blank_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_reg.mode == ESC_OFF && st_reg.blank == 16'h0000 |=> st_reg.blank == 16'h0000)
    else $error("blanking armed in shutdown");
  a_rt_shutdown: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !rt_s |=> st_reg.mode == ESC_OFF)
    else $error("running with bad frequency resistor");

  // assertions: sync count, changeover and phase slide
  a_spread_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    use_sync_clk_o |-> !spread_en_o)
    else $error("spread active on sync");
  a_lock_count: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_reg.lock == ESC_COUNT && st_next.lock == ESC_ALIGN |-> st_reg.vcnt == 12'(LOCK_COUNT - 1))
    else $error("lock before count");
  sequence s_adopt;
    st_reg.lock == ESC_COUNT ##1 st_reg.lock == ESC_ALIGN;
  endsequence
  a_changeover: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_adopt |-> st_reg.changeover)
    else $error("frequency adopted without changeover cycle");
  a_phase_nudge: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    phase_adv_o || phase_ret_o |-> use_sync_clk_o && !(phase_adv_o && phase_ret_o))
    else $error("phase nudge outside alignment");
  a_bad_restart: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    bad_ev |=> st_reg.lock == ESC_FREE && st_reg.vcnt == 12'h000)
    else $error("bad edge kept count");
  a_silence_restart: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_reg.gap > 16'(SYNC_PER_MAX_CYC) |=> st_reg.lock == ESC_FREE)
    else $error("count kept after sync stopped");

  // assertions: flag
  sequence s_not_run;
    st_reg.mode != ESC_RUN;
  endsequence
  a_flag_en_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_not_run ##1 s_not_run |-> !st_reg.flag)
    else $error("flag high while disabled");
  a_flag_soft: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !st_reg.ss_end |=> !st_reg.flag)
    else $error("flag high during soft start");
  a_flag_filter: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    st_reg.flag && !fbw_s && st_reg.okf == 16'h0000 && st_reg.mode == ESC_RUN
    ##1 (st_reg.mode == ESC_RUN && !fbw_s) |-> st_reg.flag)
    else $error("flag dropped without filter");
endmodule : esc_ctrl

//--- esc_src.sv
`timescale 1ns/1ps
// stand-in for the circuit that drives the shared enable/sync pin
module esc_src #(
  parameter int unsigned HALF_NS = 500 // 1 MHz train, inside 200 kHz..2.2 MHz
) (
  input  wire logic [1:0] level_i,
  input  wire logic       sync_on_i,
  input  wire logic       amp_good_i,
  output logic            en_wake_o,
  output logic            en_high_o,
  output logic            amp_ok_o
);
  logic pulse_reg;

  // pulse train runs only when asked; both halves far below blanking
  initial begin
    pulse_reg = 1'b0;
    forever begin
      #(HALF_NS);
      pulse_reg = sync_on_i ? ~pulse_reg : 1'b0;
    end
  end

  // pin comparators; the frequency resistor pin is never pulsed
  assign en_wake_o = sync_on_i | (level_i != 2'b00);
  assign en_high_o = sync_on_i ? pulse_reg : (level_i == 2'b10);
  assign amp_ok_o  = sync_on_i & amp_good_i & pulse_reg;
endmodule : esc_src

//--- esc_ctrl_bench.sv
`timescale 1ns/1ps
module esc_ctrl_bench;
  import esc_pkg::*;
  localparam int unsigned OKF = 20;
  localparam int unsigned SSC = 100;
  localparam int unsigned LCK = 8;

  logic       clk_i, sys_rst_i, sync_clk_i, sync_rst_i;
  logic       en_wake_i, en_high_i, sync_amp_ok_i;
  logic       vin_ok_i, vin_min_i, rt_ok_i, fb_in_window_i, ss_done_i, osc_tick_i;
  logic       vcc_on_o, switch_node_en_o, spread_en_o, sync_locked_o, use_sync_clk_o;
  logic       phase_adv_o, phase_ret_o, output_ok_flag_o, output_ok_flag_oe_o;
  logic [1:0] level;
  logic       sync_on, amp_good;
  int         n_errors = 0;
  int         checked  = 0;

  esc_ctrl #(.OKF_FALL_CYCLES(OKF), .SS_CYCLES(SSC), .LOCK_COUNT(LCK)) dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sync_clk_i(sync_clk_i),
    .sync_rst_i(sync_rst_i), .en_wake_i(en_wake_i), .en_high_i(en_high_i),
    .sync_amp_ok_i(sync_amp_ok_i), .vin_ok_i(vin_ok_i), .vin_min_i(vin_min_i),
    .rt_ok_i(rt_ok_i), .fb_in_window_i(fb_in_window_i), .ss_done_i(ss_done_i),
    .osc_tick_i(osc_tick_i), .vcc_on_o(vcc_on_o), .switch_node_en_o(switch_node_en_o),
    .spread_en_o(spread_en_o), .sync_locked_o(sync_locked_o),
    .use_sync_clk_o(use_sync_clk_o), .phase_adv_o(phase_adv_o),
    .phase_ret_o(phase_ret_o), .output_ok_flag_o(output_ok_flag_o),
    .output_ok_flag_oe_o(output_ok_flag_oe_o));

  esc_src src (.level_i(level), .sync_on_i(sync_on), .amp_good_i(amp_good),
    .en_wake_o(en_wake_i), .en_high_o(en_high_i), .amp_ok_o(sync_amp_ok_i));

  // 100 ns system clock and unrelated 30 ns link clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    sync_clk_i = 1'b0;
    #7;
    forever #15 sync_clk_i = ~sync_clk_i;
  end

  // compare one output bit with its expected value
  task automatic check(input logic seen, input logic exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s is %b", $time, what, seen);
    end
  endtask : check

  // step n edges, then settle just after the last one
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #10;
  endtask : cyc

  task automatic tally_and_finish;
    if (n_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // shutdown, standby and run decoding, supply and resistor gating
  task automatic t_modes;
    level = 2'd0;
    cyc(8);
    check(vcc_on_o, 1'b0, "vcc off");
    check(switch_node_en_o, 1'b0, "sw off");
    level = 2'd1;
    cyc(8);
    check(vcc_on_o, 1'b1, "vcc standby");
    check(switch_node_en_o, 1'b0, "sw standby");
    level = 2'd2;
    cyc(8);
    check(switch_node_en_o, 1'b1, "sw run");
    vin_ok_i = 1'b0;
    cyc(8);
    check(switch_node_en_o, 1'b0, "sw low supply");
    vin_ok_i = 1'b1;
    rt_ok_i  = 1'b0;
    cyc(8);
    check(switch_node_en_o, 1'b0, "sw bad resistor");
    check(vcc_on_o, 1'b0, "vcc bad resistor");
    rt_ok_i = 1'b1;
    cyc(8);
    check(switch_node_en_o, 1'b1, "sw resistor ok");
  endtask : t_modes

  // open-drain flag: soft start, filter, window and enable
  task automatic t_flag;
    level = 2'd1;
    cyc(8);
    level          = 2'd2;
    fb_in_window_i = 1'b1;
    ss_done_i      = 1'b0;
    cyc(20);
    check(output_ok_flag_oe_o, 1'b1, "flag in soft start");
    ss_done_i = 1'b1;
    cyc(8);
    check(output_ok_flag_oe_o, 1'b0, "flag released");
    check(output_ok_flag_o, 1'b0, "flag data");
    fb_in_window_i = 1'b0;
    cyc(OKF / 2);
    fb_in_window_i = 1'b1;
    cyc(OKF);
    check(output_ok_flag_oe_o, 1'b0, "flag after glitch");
    fb_in_window_i = 1'b0;
    cyc(OKF - 1);
    check(output_ok_flag_oe_o, 1'b0, "flag inside filter");
    cyc(8);
    check(output_ok_flag_oe_o, 1'b1, "flag after filter");
    fb_in_window_i = 1'b1;
    cyc(8);
    level = 2'd1;
    cyc(8);
    check(output_ok_flag_oe_o, 1'b1, "flag enable low");
  endtask : t_flag

  // valid sync train: adopt frequency, slide phase, lock, then stop and shut down
  task automatic t_sync;
    int i;
    int nudges;
    nudges = 0;
    level  = 2'd2;
    cyc(8);
    check(spread_en_o, 1'b1, "spread free run");
    amp_good = 1'b1;
    sync_on  = 1'b1; // started only after run is reached
    for (i = 0; i < (LCK + 6) * 10 && use_sync_clk_o !== 1'b1; i++) cyc(1);
    check(use_sync_clk_o, 1'b1, "sync adopted");
    check(spread_en_o, 1'b0, "spread off");
    check(sync_locked_o, 1'b0, "locked before align");
    // first nudge seen: report the oscillator edge as coinciding from then on
    for (i = 0; i < 400 && sync_locked_o !== 1'b1; i++) begin
      cyc(1);
      check(switch_node_en_o, 1'b1, "sw during pulses");
      if (phase_adv_o === 1'b1 || phase_ret_o === 1'b1) begin
        nudges++;
        osc_tick_i = 1'b1;
      end
    end
    check(sync_locked_o, 1'b1, "phase locked");
    check(nudges > 0 && i < 60, 1'b1, "phase nudged before lock");
    osc_tick_i = 1'b0;
    for (i = 0; i < 40; i++) begin
      cyc(1);
      check(sync_locked_o, 1'b1, "lock held");
    end
    sync_on = 1'b0;
    level   = 2'd0; // held low past the longest blanking
    cyc(100);
    check(switch_node_en_o, 1'b1, "sw still blanked");
    check(use_sync_clk_o, 1'b0, "sync dropped on silence");
    check(sync_locked_o, 1'b0, "lock dropped on silence");
    check(spread_en_o, 1'b1, "spread back");
    cyc(BLANK_CYC);
    check(switch_node_en_o, 1'b0, "sw after blanking");
    check(vcc_on_o, 1'b0, "shut down after blanking");
  endtask : t_sync

  // pulses without amplitude never count; shutdown ends in time
  task automatic t_bad_amp;
    level = 2'd2;
    cyc(8);
    amp_good = 1'b0;
    sync_on  = 1'b1;
    cyc(LCK * 30);
    check(use_sync_clk_o, 1'b0, "sync with low amplitude");
    check(spread_en_o, 1'b1, "spread kept");
    sync_on = 1'b0;
    level   = 2'd0;
    cyc(8);
    check(vcc_on_o, 1'b0, "vcc shutdown");
  endtask : t_bad_amp

  initial begin
    {level, sync_on, amp_good} = '0;
    {vin_ok_i, rt_ok_i, fb_in_window_i, ss_done_i, osc_tick_i} = '0;
    vin_min_i  = 1'b1;
    sys_rst_i  = 1'b1;
    sync_rst_i = 1'b1;
    cyc(5);
    check(output_ok_flag_oe_o, 1'b1, "flag in reset");
    check(vcc_on_o, 1'b0, "vcc in reset");
    cyc(1);
    sys_rst_i  = 1'b0;
    sync_rst_i = 1'b0;
    vin_ok_i   = 1'b1;
    rt_ok_i    = 1'b1;
    t_modes();
    t_flag();
    t_sync();
    t_bad_amp();
    tally_and_finish();
  end

  // cut a hang well past the expected run length
  initial begin
    #1000000;
    n_errors++;
    tally_and_finish();
  end
endmodule : esc_ctrl_bench
